/* logic/afc_loop.sv */
// Frequency-correction loop: loop filter, limiter, divider mapping and bus slave.
// Contract
// [R1] Loop input is DC of second demodulator.
// [R2] Correction path bypasses pre-demodulation lowpass filter.
// [R3] Always-on or timed around signal identification.
// [R4] Timed: start or freeze, then hold.
// [R5] ASK reception updates only while data high.
// [R6] Correction clamped to programmable magnitude limit.
// [R7] Software keeps limit at most 42 kHz.
// [R8] Integrator loop with two programmable gains.
// [R9] Bandwidth about 1.3 times first gain.
// [R10] Software sets gains from bit rate.
// [R11] Acquire during preamble, then hold correction.
// [R12] Offset mapped to divider factor correction.
// [R13] Fraction saturates at integer boundary.
// [R14] Signed readout, 2.68 kHz per step.
// [R15] Modulator takes 22 bits, LSB one.
// [R16] Third-order modulator drives multi-modulus divider.
// [R17] Band divider: one, two or three.
// [R18] Quadrature divide by four, orthogonal phases.
// [R19] Held value kept until restart event.
//
// The placing of the registers and register access over Wishbone were left to the implementer.
`timescale 1ns/1ns
module afc_loop #(
   parameter int DW        = 12,
   parameter int SCW       = 10,
   parameter int OFS_SCALE = 256
) (
   input  wire logic                            core_clk_i,
   input  wire logic                            nrst_i,
   input  wire logic                            wb_cyc_i,
   input  wire logic                            wb_stb_i,
   input  wire logic                            wb_we_i,
   input  wire logic [7:0]                      wb_adr_i,
   input  wire logic [3:0]                      wb_sel_i,
   input  wire logic [31:0]                     wb_dat_i,
   output logic [31:0]                          wb_dat_o,
   output logic                                 wb_ack_o,
   input  wire logic signed [DW-1:0]            afc_smp_i,
   input  wire logic                            afc_smp_vld_i,
   input  wire logic                            ask_data_i,
   input  wire logic                            sig_ident_i,
   input  wire logic                            rx_start_i,
   input  wire logic                            vco_tick_i,
   output logic [afc_pkg::SDM_W-1:0]            sdm_word_o,
   output logic [afc_pkg::INT_W:0]              mmd_div_o,
   output logic                                 lo_i_o,
   output logic                                 lo_q_o,
   output logic                                 afc_active_o,
   output logic                                 afc_held_o
);
   import afc_pkg::*;

   localparam logic [SCW-1:0] SCALE = SCW'(OFS_SCALE);

   typedef struct packed {
      afc_state_e              st;
      logic                    ack;
      logic [31:0]             dat;
      logic                    en;
      logic                    timed;
      logic                    freeze;
      logic                    ask;
      logic [1:0]              band;
      logic [OW-1:0]           lim;
      logic [KW-1:0]           k1;
      logic [KW-1:0]           k2;
      logic [DUR_W-1:0]        dur;
      logic [INT_W-1:0]        pint;
      logic [FRAC_W-1:0]       pfrac;
      logic                    counting;
      logic [DUR_W-1:0]        dcnt;
      logic signed [AW-1:0]    acc1;
      logic signed [AW-1:0]    acc2;
      logic [SDM_W-1:0]        word;
      logic                    sat;
      logic [INT_W:0]          mmd;
      logic [1:0]              bcnt;
      logic [1:0]              quad;
   } afc_regs_s;

   afc_regs_s                  r;
   afc_regs_s                  n;
   logic                       bus_req;
   logic                       wr;
   logic                       rd;
   logic [7:0]                 adr;
   logic [31:0]                ctrl_w;
   logic [31:0]                mrg;
   logic                       upd;
   logic                       restart;
   logic signed [MW-1:0]       e;
   logic signed [MW-1:0]       p1;
   logic signed [MW-1:0]       p2;
   logic signed [MW-1:0]       a2n;
   logic signed [MW-1:0]       a1n;
   logic signed [OW-1:0]       off;
   logic signed [OW+SCW:0]     corr;
   logic [INT_W+FRAC_W:0]      base;
   logic [INT_W+FRAC_W:0]      sum;
   logic signed [SDM_YW-1:0]   sdm_y;
   logic [1:0]                 bdiv;

   // Byte-lane merge for a write with byte enables.
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
      logic [31:0] m;
      m = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            m[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return m;
   endfunction

   // Symmetric clamp of a loop quantity to the programmed limit, which is held
   // in readout units and widened by the fractional bits of the integrators.
   function automatic logic signed [AW-1:0] clamp(input logic signed [MW-1:0] x,
                                                  input logic [OW-1:0]        lim);
      logic signed [MW-1:0] hi;
      logic signed [AW-1:0] y;
      hi = $signed({{(MW-OW-FB){1'b0}}, lim, {FB{1'b0}}});
      if (x > hi) begin
         y = hi[AW-1:0];
      end else if (x < -hi) begin
         y = -hi[AW-1:0];
      end else begin
         y = x[AW-1:0];
      end
      return y;
   endfunction

   afc_sdm3 u_sdm (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .word_i     (r.word),
      .y_o        (sdm_y)
   );

   always_comb begin
      n = r;
      adr = {wb_adr_i[7:2], 2'b00};
      bus_req = wb_cyc_i & wb_stb_i & ~r.ack;
      wr = bus_req & wb_we_i;
      rd = bus_req & ~wb_we_i;
      ctrl_w = '0;
      ctrl_w[CTRL_EN_BIT] = r.en;
      ctrl_w[CTRL_TIMED_BIT] = r.timed;
      ctrl_w[CTRL_FREEZE_BIT] = r.freeze;
      ctrl_w[CTRL_ASK_BIT] = r.ask;
      ctrl_w[CTRL_BAND_LSB +: 2] = r.band;
      mrg = '0;
      off = r.acc1[AW-1:FB];

      // Classic single-cycle answer: ack one edge after the strobe, then drop.
      n.ack = bus_req;
      n.dat = '0;
      if (rd) begin
         case (adr)
            CTRL_OFS:  n.dat = ctrl_w;
            LIMIT_OFS: n.dat = {20'h00000, r.lim};
            K1_OFS:    n.dat = {24'h000000, r.k1};
            K2_OFS:    n.dat = {24'h000000, r.k2};
            DUR_OFS:   n.dat = {16'h0000, r.dur};
            PINT_OFS:  n.dat = {24'h000000, r.pint};
            PFRAC_OFS: n.dat = {11'h000, r.pfrac};
            OFFS_OFS: begin
               if (r.en) begin
                  n.dat[OW-1:0] = off; // [R14]
                  n.dat[OW +: 4] = {4{off[OW-1]}};
               end
               n.dat[STAT_ACTIVE_BIT] = (r.st == AFC_RUN);
               n.dat[STAT_HELD_BIT] = (r.st == AFC_HOLD);
               n.dat[STAT_SAT_BIT] = r.sat;
            end
            default: n.dat = '0;
         endcase
      end

      // Register writes; unmapped and read-only words accept and ignore data.
      if (wr) begin
         case (adr)
            CTRL_OFS: begin
               mrg = be_merge(ctrl_w, wb_dat_i, wb_sel_i);
               n.en = mrg[CTRL_EN_BIT];
               n.timed = mrg[CTRL_TIMED_BIT];
               n.freeze = mrg[CTRL_FREEZE_BIT];
               n.ask = mrg[CTRL_ASK_BIT];
               n.band = mrg[CTRL_BAND_LSB +: 2];
            end
            LIMIT_OFS: begin
               mrg = be_merge({20'h00000, r.lim}, wb_dat_i, wb_sel_i);
               n.lim = mrg[OW-1:0];
            end
            K1_OFS: begin
               mrg = be_merge({24'h000000, r.k1}, wb_dat_i, wb_sel_i);
               n.k1 = mrg[KW-1:0]; // [R8]
            end
            K2_OFS: begin
               mrg = be_merge({24'h000000, r.k2}, wb_dat_i, wb_sel_i);
               n.k2 = mrg[KW-1:0]; // [R8]
            end
            DUR_OFS: begin
               mrg = be_merge({16'h0000, r.dur}, wb_dat_i, wb_sel_i);
               n.dur = mrg[DUR_W-1:0];
            end
            PINT_OFS: begin
               mrg = be_merge({24'h000000, r.pint}, wb_dat_i, wb_sel_i);
               n.pint = mrg[INT_W-1:0];
            end
            PFRAC_OFS: begin
               mrg = be_merge({11'h000, r.pfrac}, wb_dat_i, wb_sel_i);
               n.pfrac = mrg[FRAC_W-1:0];
            end
            default: n.pint = r.pint;
         endcase
      end

      // A new reception restarts a timed loop; in always-on mode it is ignored
      // so a continuously tracking loop never loses its lock.
      restart = rx_start_i & r.timed;

      // Activity sequencing. Duration counts demodulator samples, so it scales
      // with the sample rate rather than with the bus clock.
      unique case (r.st)
         AFC_OFF: begin
            n.counting = 1'b0;
            if (r.en) begin
               n.st = (r.timed & ~r.freeze) ? AFC_WAIT : AFC_RUN; // [R3]
            end
         end
         AFC_WAIT: begin
            if (!r.en) begin
               n.st = AFC_OFF;
            end else if (sig_ident_i) begin
               n.st = AFC_RUN; // [R4]
               n.counting = 1'b1;
               n.dcnt = r.dur;
            end
         end
         AFC_RUN: begin
            if (!r.en) begin
               n.st = AFC_OFF;
            end else if (restart) begin
               n.st = r.freeze ? AFC_RUN : AFC_WAIT; // [R19]
               n.counting = 1'b0;
            end else if (r.timed && r.freeze && !r.counting && sig_ident_i) begin
               n.counting = 1'b1; // [R4]
               n.dcnt = r.dur;
            end else if (r.counting && r.dcnt == '0) begin
               n.st = AFC_HOLD; // [R4]
               n.counting = 1'b0;
            end else if (r.counting && afc_smp_vld_i) begin
               n.dcnt = r.dcnt - 1'b1;
            end
         end
         AFC_HOLD: begin
            if (!r.en) begin
               n.st = AFC_OFF;
            end else if (restart) begin
               n.st = r.freeze ? AFC_RUN : AFC_WAIT; // [R19]
            end
         end
      endcase

      // Loop filter: the second integrator feeds the first, so the offset is
      // the integral of k1*e plus the double integral of k2*e. The input is the raw
      // second-demodulator sample, whose mean the integrators extract.
      upd = (r.st == AFC_RUN) & afc_smp_vld_i & (~r.ask | ask_data_i); // [R5]
      e = MW'(afc_smp_i); // [R2]
      p1 = e * $signed({{(MW-KW){1'b0}}, r.k1}); // [R9]
      p2 = e * $signed({{(MW-KW){1'b0}}, r.k2});
      a2n = MW'(r.acc2) + (p2 >>> K_SHIFT);
      a1n = MW'(r.acc1) + (p1 >>> K_SHIFT) + MW'(clamp(a2n, r.lim));
      if (!r.en || (restart && r.st != AFC_OFF)) begin
         n.acc1 = '0; // [R19]
         n.acc2 = '0;
      end else if (upd) begin
         n.acc2 = clamp(a2n, r.lim); // [R1]
         n.acc1 = clamp(a1n, r.lim); // [R6]
      end else begin
         // Re-clamping while idle keeps a held value inside a lowered limit.
         n.acc2 = clamp(MW'(r.acc2), r.lim); // [R6]
         n.acc1 = clamp(MW'(r.acc1), r.lim); // [R6]
      end

      // Offset to divider factor: one readout step is a fixed fraction of the
      // reference, so the same scale holds in every band.
      corr = off * $signed({1'b0, SCALE}); // [R12]
      base = {1'b0, r.pint, r.pfrac};
      sum = base + (INT_W+FRAC_W+1)'(corr);
      n.sat = 1'b0;
      if (sum[INT_W+FRAC_W:FRAC_W] != {1'b0, r.pint}) begin
         n.sat = 1'b1; // [R13]
         n.word = corr[OW+SCW] ? {{FRAC_W{1'b0}}, 1'b1} : {SDM_W{1'b1}}; // [R13]
      end else begin
         n.word = {sum[FRAC_W-1:0], 1'b1}; // [R15]
      end

      // Divider modulus per reference cycle: integer part plus modulator digit.
      n.mmd = (INT_W+1)'($signed({2'b00, r.pint}) + sdm_y); // [R16]

      // Band divider clocked by VCO ticks, then a two-stage Johnson counter
      // whose outputs are a quarter period apart.
      bdiv = (r.band == 2'h0) ? 2'h1 : r.band; // [R17]
      if (vco_tick_i) begin
         if (r.bcnt >= bdiv - 2'h1) begin
            n.bcnt = 2'h0;
            n.quad = {r.quad[0], ~r.quad[1]}; // [R18]
         end else begin
            n.bcnt = r.bcnt + 2'h1;
         end
      end
   end

   // State register; reset loads every control field with its defined value.
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         r <= '0;
         r.st <= AFC_OFF;
         r.lim <= LIMIT_RST;
         r.k1 <= K1_RST;
         r.k2 <= K2_RST;
         r.dur <= DUR_RST;
         r.band <= BAND_RST;
         r.pint <= PINT_RST;
         r.pfrac <= PFRAC_RST;
         r.word <= {PFRAC_RST, 1'b1};
      end else begin
         r <= n;
      end
   end

   // Every output is a field of the state register.
   assign wb_dat_o = r.dat;
   assign wb_ack_o = r.ack;
   assign sdm_word_o = r.word;
   assign mmd_div_o = r.mmd;
   assign lo_i_o = r.quad[0];
   assign lo_q_o = r.quad[1];
   // One-hot state bits drive the status pins directly, with no decode after the flop.
   assign afc_active_o = r.st[1];
   assign afc_held_o = r.st[3];

endmodule

/* logic/afc_pkg.sv */
// Shared constants and types of the frequency-correction loop.
package afc_pkg;

   // Datapath widths of the loop filter and the synthesizer control word.
   localparam int OW     = 12;
   localparam int FB     = 8;
   localparam int AW     = OW + FB;
   localparam int MW     = 26;
   localparam int KW     = 8;
   localparam int DUR_W  = 16;
   localparam int INT_W  = 8;
   localparam int FRAC_W = 21;
   localparam int SDM_W  = FRAC_W + 1;
   localparam int SDM_YW = 4;

   // Right shift applied to each gain product before it enters an integrator.
   localparam int K_SHIFT = 4;

   // Register byte offsets on the bus.
   localparam logic [7:0] CTRL_OFS  = 8'h00;
   localparam logic [7:0] LIMIT_OFS = 8'h04;
   localparam logic [7:0] K1_OFS    = 8'h08;
   localparam logic [7:0] K2_OFS    = 8'h0c;
   localparam logic [7:0] DUR_OFS   = 8'h10;
   localparam logic [7:0] PINT_OFS  = 8'h14;
   localparam logic [7:0] PFRAC_OFS = 8'h18;
   localparam logic [7:0] OFFS_OFS  = 8'h1c;

   // Field positions in the control and readout words.
   localparam int CTRL_EN_BIT     = 0;
   localparam int CTRL_TIMED_BIT  = 1;
   localparam int CTRL_FREEZE_BIT = 2;
   localparam int CTRL_ASK_BIT    = 3;
   localparam int CTRL_BAND_LSB   = 4;
   localparam int STAT_ACTIVE_BIT = 16;
   localparam int STAT_HELD_BIT   = 17;
   localparam int STAT_SAT_BIT    = 18;

   // Values after reset.
   localparam logic [OW-1:0]     LIMIT_RST = 12'h00f;
   localparam logic [KW-1:0]     K1_RST    = 8'h10;
   localparam logic [KW-1:0]     K2_RST    = 8'h10;
   localparam logic [DUR_W-1:0]  DUR_RST   = 16'h0100;
   localparam logic [1:0]        BAND_RST  = 2'h1;
   localparam logic [INT_W-1:0]  PINT_RST  = 8'h00;
   localparam logic [FRAC_W-1:0] PFRAC_RST = 21'h000000;

   // Loop activity states.
   typedef enum logic [3:0] {
      AFC_OFF  = 4'b0001,
      AFC_RUN  = 4'b0010,
      AFC_WAIT = 4'b0100,
      AFC_HOLD = 4'b1000
   } afc_state_e;

endpackage

/* logic/afc_sdm3.sv */
// Third-order cascaded sigma-delta modulator steering the multi-modulus divider.
`timescale 1ns/1ns
module afc_sdm3 (
   input  wire logic                         core_clk_i,
   input  wire logic                         nrst_i,
   input  wire logic [afc_pkg::SDM_W-1:0]    word_i,
   output logic signed [afc_pkg::SDM_YW-1:0] y_o
);
   import afc_pkg::*;

   typedef struct packed {
      logic [SDM_W-1:0]         acc1;
      logic [SDM_W-1:0]         acc2;
      logic [SDM_W-1:0]         acc3;
      logic                     c2z;
      logic                     c3z;
      logic                     c3zz;
      logic signed [SDM_YW-1:0] y;
   } afc_sdm_s;

   afc_sdm_s       r;
   afc_sdm_s       n;
   logic [SDM_W:0] s1;
   logic [SDM_W:0] s2;
   logic [SDM_W:0] s3;

   // Three accumulators in cascade; carries are combined by the noise-shaping
   // difference network so the output spans minus three to plus four.
   always_comb begin
      n = r;
      s1 = {1'b0, r.acc1} + {1'b0, word_i};
      s2 = {1'b0, r.acc2} + {1'b0, s1[SDM_W-1:0]};
      s3 = {1'b0, r.acc3} + {1'b0, s2[SDM_W-1:0]};
      n.acc1 = s1[SDM_W-1:0];
      n.acc2 = s2[SDM_W-1:0];
      n.acc3 = s3[SDM_W-1:0];
      n.c2z  = s2[SDM_W];
      n.c3z  = s3[SDM_W];
      n.c3zz = r.c3z;
      n.y = $signed({3'b000, s1[SDM_W]}) + $signed({3'b000, s2[SDM_W]})
          - $signed({3'b000, r.c2z}) + $signed({3'b000, s3[SDM_W]})
          - $signed({2'b00, r.c3z, 1'b0}) + $signed({3'b000, r.c3zz});
   end

   // State register.
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign y_o = r.y;

endmodule

/* verification/afc_demod_model.sv */
// Far side model: second demodulator samples and the VCO edge strobe.
`timescale 1ns/1ns
module afc_demod_model #(
   parameter int PER = 4
) (
   input  wire logic               core_clk_i,
   input  wire logic               nrst_i,
   input  wire logic signed [11:0] dc_i,
   output logic signed [11:0]      smp_o,
   output logic                    vld_o,
   output logic                    tick_o
);
   logic [3:0] cnt_q;
   initial {cnt_q, vld_o, tick_o, smp_o} = '0;
   // One raw sample every PER cycles carries the offset as its DC part.
   always @(posedge core_clk_i) begin
      if (!nrst_i) begin
         {cnt_q, vld_o, tick_o, smp_o} <= '0;
      end else begin
         cnt_q  <= (cnt_q == 4'(PER - 1)) ? 4'h0 : cnt_q + 4'h1;
         vld_o  <= (cnt_q == 4'h0);
         // Between strobes the line shows junk, so stale data cannot pass.
         smp_o  <= (cnt_q == 4'h0) ? dc_i : ~smp_o;
         tick_o <= ~tick_o;
      end
   end
endmodule

/* verification/afc_loop_bench.sv */
// Self-checking bench for the frequency-correction loop.
`timescale 1ns/1ns
module afc_loop_bench;
   import afc_pkg::*;
   logic               core_clk_i = 1'b0;
   logic               nrst_i = 1'b0;
   logic               cyc = 1'b0, stb = 1'b0, we = 1'b0, ask = 1'b0, sig = 1'b0, rxs = 1'b0;
   logic [7:0]         adr = 8'h0;
   logic [3:0]         sel = 4'h0;
   logic [31:0]        wdat = 32'h0, rdat, wm, rnd = 32'd22;
   logic               ack, vld, tick, lo_i, lo_q, act, hld, lo_prev = 1'b0;
   logic signed [11:0] smp, dc = 12'sh0;
   logic [SDM_W-1:0]   word;
   logic [INT_W:0]     mmd;
   logic [31:0]        exp_q[$], msk_q[$];
   logic [31:0]        rst_v[9] = '{32'h10, 32'hf, 32'h10, 32'h10, 32'h100, 0, 0, 0, 0};
   int                 err_total = 0, n_compared = 0, cyc_n = 0, ticks = 0, per_v = 0;

   always #5 core_clk_i = ~core_clk_i;

   afc_loop dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .afc_smp_i(smp), .afc_smp_vld_i(vld), .ask_data_i(ask),
      .sig_ident_i(sig), .rx_start_i(rxs), .vco_tick_i(tick), .sdm_word_o(word),
      .mmd_div_o(mmd), .lo_i_o(lo_i), .lo_q_o(lo_q), .afc_active_o(act), .afc_held_o(hld));
   afc_demod_model u_far (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .dc_i(dc),
      .smp_o(smp), .vld_o(vld), .tick_o(tick));

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   // Classic cycle: hold everything until ack is sampled, then release.
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge core_clk_i);
      {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, d, s};
      do @(posedge core_clk_i); while (ack !== 1'b1);
      {cyc, stb, we} <= 3'b000;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, 4'hf);
   endtask
   // The expected value is noted before the request goes out.
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      bus(a, 1'b0, 32'h0, 4'hf);
   endtask
   task automatic ident();
      sig <= 1'b1;
      tk(1);
      sig <= 1'b0;
   endtask

   // Watcher: compares read data with the oldest note and times the phases.
   always @(posedge core_clk_i) begin
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
         wm = msk_q.pop_front();
         chk(rdat & wm, exp_q.pop_front());
      end
      if (tick === 1'b1) ticks++;
      if (lo_i === 1'b1 && lo_prev === 1'b0) begin
         per_v = ticks;
         ticks = 0;
      end
      lo_prev = lo_i;
      cyc_n++;
      if (cyc_n == 20000) begin
         err_total++;
         $display("BAD %0t run timed out", $time);
         stop_test();
      end
   end

   initial begin
      tk(16);
      nrst_i <= 1'b1;
      // Writes to the readout and to a hole are ignored, so reset values stay.
      wr(OFFS_OFS, 32'hffffffff);
      wr(8'h20, 32'hffffffff);
      for (int i = 0; i < 9; i++) rd(8'(i * 4), rst_v[i], 32'hffffffff);
      chk(32'(word), 32'h1);
      $display("test reset done");
      wr(K1_OFS, 32'h10);
      wr(K2_OFS, 32'h10);
      wr(PINT_OFS, 32'h20);
      wr(PFRAC_OFS, 32'h012345);
      bus(PFRAC_OFS, 1'b1, 32'hffffffaa, 4'h1);
      rd(PFRAC_OFS, 32'h0123aa, 32'hffffffff);
      chk(32'(word), {10'h0, 21'h0123aa, 1'b1});
      $display("test divider word done");
      rnd = xs(rnd);
      dc <= 12'(100 + int'(rnd[7:0]));
      wr(CTRL_OFS, 32'h11);
      tk(600);
      rd(OFFS_OFS, 32'h1000f, 32'h7ffff);
      chk(32'(word), {10'h0, 21'h0132aa, 1'b1});
      rnd = xs(rnd);
      dc <= 12'(-(100 + int'(rnd[7:0])));
      tk(900);
      rd(OFFS_OFS, 32'h1fff1, 32'h7ffff);
      chk(32'(word), {10'h0, 21'h0114aa, 1'b1});
      wr(LIMIT_OFS, 32'h5);
      tk(8);
      rd(OFFS_OFS, 32'h1fffb, 32'h1ffff);
      wr(LIMIT_OFS, 32'hf);
      $display("test continuous done");
      wr(CTRL_OFS, 32'h0);
      dc <= 12'sd300;
      wr(CTRL_OFS, 32'h19);
      tk(400);
      rd(OFFS_OFS, 32'h10000, 32'h1ffff);
      ask <= 1'b1;
      tk(400);
      rd(OFFS_OFS, 32'h1000f, 32'h1ffff);
      ask <= 1'b0;
      $display("test ask done");
      wr(CTRL_OFS, 32'h0);
      wr(DUR_OFS, 32'h4);
      dc <= 12'sd2047;
      wr(CTRL_OFS, 32'h13);
      tk(40);
      rd(OFFS_OFS, 32'h0, 32'h3ffff);
      ident();
      tk(60);
      rd(OFFS_OFS, 32'h2000f, 32'h3ffff);
      chk(32'({act, hld}), 32'h1);
      dc <= -12'sd2047;
      tk(100);
      rd(OFFS_OFS, 32'h2000f, 32'h3ffff);
      rxs <= 1'b1;
      tk(1);
      rxs <= 1'b0;
      tk(10);
      rd(OFFS_OFS, 32'h0, 32'h3ffff);
      $display("test timed start done");
      wr(CTRL_OFS, 32'h0);
      dc <= 12'sd2047;
      wr(CTRL_OFS, 32'h17);
      tk(40);
      rd(OFFS_OFS, 32'h1000f, 32'h3ffff);
      ident();
      tk(60);
      rd(OFFS_OFS, 32'h2000f, 32'h3ffff);
      $display("test timed freeze done");
      wr(CTRL_OFS, 32'h0);
      wr(PFRAC_OFS, 32'h1fff00);
      wr(CTRL_OFS, 32'h11);
      tk(100);
      rd(OFFS_OFS, 32'h5000f, 32'h7ffff);
      chk(32'(word), {10'h0, 21'h1fffff, 1'b1});
      wr(CTRL_OFS, 32'h0);
      wr(PFRAC_OFS, 32'h100);
      dc <= -12'sd2047;
      wr(CTRL_OFS, 32'h11);
      tk(100);
      chk(32'(word), 32'h1);
      $display("test saturation done");
      // Band field 0 acts as divide by one; each phase period is four outputs.
      for (int b = 0; b < 4; b++) begin
         wr(CTRL_OFS, 32'(b << 4));
         tk(200);
         chk(32'(per_v), 32'((b == 0) ? 4 : 4 * b));
         chk(32'(mmd >= 9'h1d && mmd <= 9'h24), 32'h1);
      end
      $display("test band done");
      stop_test();
   end
endmodule

/* verification/afc_loop_properties.sv */
// Concurrent checks on the ports of the frequency-correction loop.
`timescale 1ns/1ns
module afc_loop_properties (
   input wire logic                       core_clk_i,
   input wire logic                       nrst_i,
   input wire logic                       wb_cyc_i,
   input wire logic                       wb_stb_i,
   input wire logic                       wb_ack_o,
   input wire logic [31:0]                wb_dat_o,
   input wire logic                       rx_start_i,
   input wire logic [afc_pkg::SDM_W-1:0]  sdm_word_o,
   input wire logic                       lo_i_o,
   input wire logic                       lo_q_o,
   input wire logic                       afc_active_o,
   input wire logic                       afc_held_o
);
   import afc_pkg::*;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   // A request that the slave has not answered yet.
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // One acknowledge cycle followed by a low one.
   sequence s_ack;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   // Nothing can move the word: no bus cycle, no restart, no integration.
   sequence s_quiet;
      !wb_cyc_i && !rx_start_i && !afc_active_o;
   endsequence
   chk_ack_follows_req: assert property (s_req |=> s_ack)
      else $error("ack did not answer the request one cycle later");
   chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack stood longer than one cycle");
   chk_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   chk_word_lsb_one: assert property (sdm_word_o[0])
      else $error("modulator word lsb low");
   chk_quad_one_step: assert property (!($changed(lo_i_o) && $changed(lo_q_o)))
      else $error("both quadrature phases moved together");
   chk_state_exclusive: assert property (!(afc_active_o && afc_held_o))
      else $error("active and held at once");
   chk_hold_after_run: assert property ($rose(afc_held_o) |-> $past(afc_active_o))
      else $error("hold entered without a run");
   // Three quiet cycles leave room for the word register's latency.
   chk_word_frozen: assert property (s_quiet [*3] |=> $stable(sdm_word_o))
      else $error("word moved while the loop was not running");
endmodule

bind afc_loop afc_loop_properties u_chk (.core_clk_i, .nrst_i, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .wb_dat_o, .rx_start_i, .sdm_word_o, .lo_i_o, .lo_q_o, .afc_active_o,
   .afc_held_o);
